// ---- verilog/phy_rx_tuning_regs.sv ----
// receive tuning, idle threshold, skew status and strap status registers
// assumes an AXI4-Lite master on sys_clk; datapath inputs share sys_clk
`include "phy_rx_tuning_params.svh"
`timescale 1ns/1ps
`default_nettype none
module phy_rx_tuning_regs
  import phy_rx_tuning_pkg::*;
#(
  parameter int LIMIT_CYC = `DESCR_LIMIT_CYC,
  parameter int MS_CYC = `MS_CYC,
  parameter bit LARGE_PKG = 1'b1
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // axi4-lite write
  input wire logic [31:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [31:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // receive datapath status in
  input wire logic rx_frame_active,
  input wire logic descrambler_locked,
  input wire logic link_raw_ok,
  input wire logic symbol_valid,
  input wire logic symbol_is_idle,
  input wire logic nibble_valid,
  input wire logic frame_end,
  input wire logic [3:0] rx_lane_a_skew,
  input wire logic [3:0] rx_lane_b_skew,
  // strap pins
  input wire logic [15:0] strap_pins,
  // controls out
  output logic rx_abort,
  output logic descrambler_recovering,
  output logic link_good,
  output logic enhanced_ternary_detect_on,
  output logic enhanced_gap_detect_on,
  output logic rx_block_decoder_skip,
  output logic scrambler_off,
  output logic early_receive_valid,
  output logic idle_mode,
  output logic odd_nibble_seen
);
  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  reg16_t tun_r;
  logic [3:0] idle_thr_r;
  reg16_t skew_r;
  reg16_t strap_r;
  logic strap_done_r;
  logic [1:0] strap_wait_r;
  reg16_t strap_s1_r;
  reg16_t strap_s2_r;
  logic [31:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_got_r;
  logic w_got_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  resp_t bresp_r;
  logic arready_r;
  logic rvalid_r;
  resp_t rresp_r;
  logic [31:0] rdata_r;
  logic [31:0] pkt_cnt_r;
  logic abort_r;
  logic lock_d_r;
  logic [31:0] ms_cnt_r;
  logic [3:0] ms_left_r;
  logic recov_r;
  logic [3:0] idle_run_r;
  logic idle_r;
  logic parity_r;
  logic odd_r;
  logic link_r;

  // -----------------------------------------------------------------
  // write channel
  // -----------------------------------------------------------------
  // address and data are taken in either order and held until both exist
  wire aw_take = s_awvalid & awready_r;
  wire w_take = s_wvalid & wready_r;
  wire wr_fire = aw_got_r & w_got_r & ~bvalid_r;
  wire b_done = bvalid_r & s_bready;
  wire aw_got_nxt = (aw_got_r | aw_take) & ~wr_fire;
  wire w_got_nxt = (w_got_r | w_take) & ~wr_fire;
  wire bvalid_nxt = wr_fire | (bvalid_r & ~s_bready);
  wire [7:0] wr_idx = aw_addr_r[9:2];
  wire wr_word = aw_addr_r[1:0] == 2'b00 && aw_addr_r[31:10] == 22'h0;
  wire wr_tun = wr_fire & wr_word & (wr_idx == `IDX_RX_TUNING);
  wire wr_thr = wr_fire & wr_word & (wr_idx == `IDX_IDLE_THR);
  wire wr_ro = wr_word & (wr_idx == `IDX_SKEW || wr_idx == `IDX_STRAP);
  wire [15:0] wmask = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
  wire [15:0] tun_nxt = (tun_r & ~(wmask & `TUN_RW_MASK)) |
    (w_data_r[15:0] & wmask & `TUN_RW_MASK);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
    end else if (ce) begin
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awready_r <= ~aw_got_nxt & ~bvalid_nxt;
      wready_r <= ~w_got_nxt & ~bvalid_nxt;
      bvalid_r <= bvalid_nxt;
    end
  end

  // payload holders carry no reset, they are qualified by the got flags
  always_ff @(posedge sys_clk) begin
    if (ce && aw_take) aw_addr_r <= s_awaddr;
    if (ce && w_take) begin
      w_data_r <= s_wdata;
      w_strb_r <= s_wstrb;
    end
  end

  // writes to read-only words succeed quietly; unmapped words error
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bresp_r <= `RESP_OKAY;
    end else if (ce && wr_fire) begin
      bresp_r <= (wr_tun | wr_thr | (wr_fire & wr_ro)) ? `RESP_OKAY : `RESP_SLVERR;
    end
  end

  // software-written fields
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tun_r <= `TUN_RESET;
      idle_thr_r <= `IDLE_THR_RESET;
    end else if (ce) begin
      if (wr_tun) tun_r <= tun_nxt;
      if (wr_thr && w_strb_r[0]) idle_thr_r <= w_data_r[3:0];
    end
  end

  // -----------------------------------------------------------------
  // read channel
  // -----------------------------------------------------------------
  // the address is decoded as it arrives; data are latched at acceptance
  wire ar_take = s_arvalid & arready_r;
  wire rvalid_nxt = ar_take | (rvalid_r & ~s_rready);
  wire [7:0] rd_idx = s_araddr[9:2];
  wire rd_word = s_araddr[1:0] == 2'b00 && s_araddr[31:10] == 22'h0;
  wire rd_tun = rd_word & (rd_idx == `IDX_RX_TUNING);
  wire rd_thr = rd_word & (rd_idx == `IDX_IDLE_THR);
  wire rd_skew = rd_word & (rd_idx == `IDX_SKEW);
  wire rd_strap = rd_word & (rd_idx == `IDX_STRAP);
  wire rd_hit = rd_tun | rd_thr | rd_skew | rd_strap;
  wire [15:0] rd_val = rd_tun ? tun_r :
    rd_thr ? (`IDLE_THR_HIGH | {12'h000, idle_thr_r}) :
    rd_skew ? skew_r :
    rd_strap ? strap_r : 16'h0000;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rresp_r <= `RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else if (ce) begin
      arready_r <= ~rvalid_nxt;
      rvalid_r <= rvalid_nxt;
      if (ar_take) begin
        rresp_r <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
        rdata_r <= {16'h0000, rd_val};
      end
    end
  end

  // -----------------------------------------------------------------
  // skew and strap status
  // -----------------------------------------------------------------
  // skew lanes come from logic on sys_clk, so no synchroniser
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      skew_r <= 16'h0000;
    end else if (ce) begin
      skew_r <= {8'h00, rx_lane_b_skew, rx_lane_a_skew};
    end
  end

  // straps are pins: two flops, then one capture after reset release
  wire [15:0] strap_mask = LARGE_PKG ? `STRAP_MASK_LARGE : `STRAP_MASK_SMALL;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      strap_s1_r <= 16'h0000;
      strap_s2_r <= 16'h0000;
      strap_r <= 16'h0000;
      strap_done_r <= 1'b0;
      strap_wait_r <= 2'd0;
    end else if (ce) begin
      strap_s1_r <= strap_pins;
      strap_s2_r <= strap_s1_r;
      // wait until the pins have passed both flops, then capture once
      if (!strap_done_r) begin
        strap_wait_r <= strap_wait_r + 2'd1;
        if (strap_wait_r == `STRAP_WAIT) begin
          strap_r <= strap_s2_r & strap_mask;
          strap_done_r <= 1'b1;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // descrambler timeout and recovery
  // -----------------------------------------------------------------
  // the packet counter saturates so a stuck frame cannot wrap back to ok
  wire limit_off = tun_r[`TUN_LIMIT_OFF];
  wire pkt_over = pkt_cnt_r >= 32'(LIMIT_CYC);
  wire lock_lost = lock_d_r & ~descrambler_locked;
  wire ms_tick = recov_r && ms_cnt_r == 32'(MS_CYC - 1);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pkt_cnt_r <= 32'h0000_0000;
      abort_r <= 1'b0;
    end else if (ce) begin
      if (!rx_frame_active) pkt_cnt_r <= 32'h0000_0000;
      else if (!pkt_over) pkt_cnt_r <= pkt_cnt_r + 32'h0000_0001;
      abort_r <= rx_frame_active & pkt_over & ~limit_off;
    end
  end

  // recovery lasts the programmed number of milliseconds after unlock
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lock_d_r <= 1'b0;
      ms_cnt_r <= 32'h0000_0000;
      ms_left_r <= 4'h0;
      recov_r <= 1'b0;
    end else if (ce) begin
      lock_d_r <= descrambler_locked;
      if (lock_lost) begin
        ms_cnt_r <= 32'h0000_0000;
        ms_left_r <= tun_r[`TUN_LIMIT_MS_HI:`TUN_LIMIT_MS_LO];
        recov_r <= tun_r[`TUN_LIMIT_MS_HI:`TUN_LIMIT_MS_LO] != 4'h0;
      end else if (ms_tick) begin
        ms_cnt_r <= 32'h0000_0000;
        ms_left_r <= ms_left_r - 4'h1;
        recov_r <= ms_left_r != 4'h1;
      end else if (recov_r) begin
        ms_cnt_r <= ms_cnt_r + 32'h0000_0001;
      end
    end
  end

  // -----------------------------------------------------------------
  // idle detector, odd nibbles, link
  // -----------------------------------------------------------------
  // the run saturates at 15 so a long idle stretch cannot wrap to zero
  wire [3:0] idle_run_nxt = !symbol_valid ? idle_run_r :
    !symbol_is_idle ? 4'h0 :
    (idle_run_r == 4'hF) ? idle_run_r : idle_run_r + 4'h1;
  wire parity_now = parity_r ^ nibble_valid;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idle_run_r <= 4'h0;
      idle_r <= 1'b0;
      parity_r <= 1'b0;
      odd_r <= 1'b0;
      link_r <= 1'b0;
    end else if (ce) begin
      idle_run_r <= idle_run_nxt;
      idle_r <= idle_run_nxt >= idle_thr_r;
      parity_r <= frame_end ? 1'b0 : parity_now;
      odd_r <= frame_end & parity_now & tun_r[`TUN_ODD_NIB];
      link_r <= tun_r[`TUN_FORCE_LINK] | link_raw_ok;
    end
  end

  // -----------------------------------------------------------------
  // outputs, all straight from flops
  // -----------------------------------------------------------------
  assign s_awready = awready_r;
  assign s_wready = wready_r;
  assign s_bvalid = bvalid_r;
  assign s_bresp = bresp_r;
  assign s_arready = arready_r;
  assign s_rvalid = rvalid_r;
  assign s_rresp = rresp_r;
  assign s_rdata = rdata_r;
  assign rx_abort = abort_r;
  assign descrambler_recovering = recov_r;
  assign link_good = link_r;
  assign enhanced_ternary_detect_on = tun_r[`TUN_TERNARY];
  assign enhanced_gap_detect_on = tun_r[`TUN_GAP];
  assign rx_block_decoder_skip = tun_r[`TUN_DEC_SKIP];
  assign scrambler_off = tun_r[`TUN_SCR_OFF];
  assign early_receive_valid = tun_r[`TUN_EARLY_DV];
  assign idle_mode = idle_r;
  assign odd_nibble_seen = odd_r;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_ABORT_CAUSE: assert property (
    ce ##1 abort_r |-> $past(rx_frame_active) && !$past(limit_off) && $past(pkt_over))
    else $error("abort without an overlong frame");
  AST_ABORT_OFF: assert property (
    ce && rx_frame_active && pkt_over && !limit_off |=> abort_r)
    else $error("overlong frame not aborted");
  AST_LINK_FORCE: assert property (
    ce && tun_r[`TUN_FORCE_LINK] |=> link_r)
    else $error("forced link not reported good");
  AST_IDLE_SET: assert property (
    ce && idle_run_nxt >= idle_thr_r |=> idle_r)
    else $error("idle mode missing at threshold");
  AST_IDLE_CLEAR: assert property (
    ce && symbol_valid && !symbol_is_idle && idle_thr_r != 4'h0 |=> !idle_r)
    else $error("idle mode held after a data symbol");
  AST_SKEW: assert property (
    ce |=> skew_r[3:0] == $past(rx_lane_a_skew) && skew_r[15:8] == 8'h00)
    else $error("lane skew not reported");
  AST_STRAP_HOLD: assert property (
    strap_done_r |=> $stable(strap_r))
    else $error("strap status changed after capture");
  AST_STRAP_RSVD: assert property (
    (strap_r & ~strap_mask) == 16'h0000)
    else $error("reserved strap bit set");
  AST_TUN_RSVD: assert property (
    tun_r[15:12] == 4'h0 ##1 tun_r[15:12] == 4'h0)
    else $error("reserved tuning bits written");
  AST_ODD: assert property (
    ce ##1 odd_r |-> $past(frame_end) && $past(tun_r[`TUN_ODD_NIB]))
    else $error("odd nibble flag without enable");
  AST_BVALID_HOLD: assert property (
    bvalid_r && !s_bready |=> bvalid_r)
    else $error("write response dropped");
  // bus, clock-enable and recovery-load checks
  AST_RVALID_HOLD: assert property (
    rvalid_r && !s_rready |=> rvalid_r && $stable(rdata_r))
    else $error("read data dropped before acceptance");
  AST_WR_BUSY: assert property (
    bvalid_r |-> !awready_r && !wready_r)
    else $error("write accepted while response pending");
  AST_FREEZE: assert property (
    !ce |=> $stable(tun_r) && $stable(idle_thr_r) && $stable(strap_r))
    else $error("state moved while clock enable low");
  AST_RECOV_LOAD: assert property (
    ce && lock_lost |=> ms_left_r == $past(tun_r[`TUN_LIMIT_MS_HI:`TUN_LIMIT_MS_LO]))
    else $error("recovery time not loaded on unlock");
endmodule // phy_rx_tuning_regs
`default_nettype wire

// ---- verilog/phy_rx_tuning_params.svh ----
// constants for the receive tuning and strap status register bank
// assumes a 125 MHz system clock and 16-bit registers on a 32-bit bus
// How it works
// - overlong packet aborted unless timeout disabled
// - timeout disable bit 11, reset 0
// - timeout ms value bits 10:7, reset 1111
// - bit 6 forces good 100M link
// - bit 5 enhanced ternary detect, reset 1
// - bit 4 enhanced gap detect, reset 0
// - bit 3 skips receive block decoder
// - bit 2 turns scrambler off
// - bit 1 flags odd nibble count
// - bit 0 selects early receive valid
// - idle mode when run reaches threshold
// - lane B skew in bits 7:4
// - lane A skew in bits 3:0
// - strap bits 15,14,13,12 shown, or 15,14,12
// - crossover straps at bits 10, 9
// - duplex bit 8, autoneg bit 7
// - speed straps 6:5 or 5 only
// - address straps 4:0 or 3:0
`ifndef PHY_RX_TUNING_PARAMS_SVH
`define PHY_RX_TUNING_PARAMS_SVH
// -----------------------------------------------------------------
// register indexes; byte address is four times the index
// -----------------------------------------------------------------
`define IDX_RX_TUNING 8'h43
`define IDX_IDLE_THR 8'h53
`define IDX_SKEW 8'h55
`define IDX_STRAP 8'h6E
// -----------------------------------------------------------------
// field positions and reset values
// -----------------------------------------------------------------
`define TUN_LIMIT_OFF 11
`define TUN_LIMIT_MS_HI 10
`define TUN_LIMIT_MS_LO 7
`define TUN_FORCE_LINK 6
`define TUN_TERNARY 5
`define TUN_GAP 4
`define TUN_DEC_SKIP 3
`define TUN_SCR_OFF 2
`define TUN_ODD_NIB 1
`define TUN_EARLY_DV 0
`define TUN_RW_MASK 16'h0FFF
`define TUN_RESET 16'h07A0
`define IDLE_THR_RESET 4'h5
`define IDLE_THR_HIGH 16'h2050
`define STRAP_MASK_LARGE 16'hF7FF
`define STRAP_MASK_SMALL 16'hD7AF
// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define CLK_MHZ 125
`define DESCR_LIMIT_US 1500
`define DESCR_LIMIT_CYC (`DESCR_LIMIT_US * `CLK_MHZ)
`define MS_US 1000
`define MS_CYC (`MS_US * `CLK_MHZ)
`define STRAP_WAIT 2'd2
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// ---- verilog/phy_rx_tuning_pkg.sv ----
// types for the receive tuning register bank
// assumes nothing beyond the params header
package phy_rx_tuning_pkg;
  typedef logic [15:0] reg16_t;
  typedef logic [1:0] resp_t;
endpackage

// ---- tb/tb.sv ----
// self-checking bench for the receive tuning and strap status register bank
// assumes the bank and a smaller-package copy share sys_clk and a bench-driven axi4-lite master
`timescale 1ns/1ps
`default_nettype none
module tb
  import phy_rx_tuning_pkg::*;
;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1;
  logic [31:0] s_awaddr = 32'h0000_0000, s_wdata = 32'h0000_0000;
  logic [31:0] s_araddr = 32'h0000_0000, s_rdata;
  logic [3:0] s_wstrb = 4'h0;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  resp_t s_bresp, s_rresp;
  logic rx_frame_active = 1'b0, descrambler_locked = 1'b1, link_raw_ok = 1'b0;
  logic symbol_valid = 1'b0, symbol_is_idle = 1'b0, nibble_valid = 1'b0, frame_end = 1'b0;
  logic [3:0] rx_lane_a_skew = 4'h0, rx_lane_b_skew = 4'h0;
  logic [15:0] strap_pins = 16'hFFFF;
  logic rx_abort, descrambler_recovering, link_good, enhanced_ternary_detect_on;
  logic enhanced_gap_detect_on, rx_block_decoder_skip, scrambler_off, early_receive_valid;
  logic idle_mode, odd_nibble_seen, seen;
  logic [31:0] rdata_small;
  int mismatches = 0, cmp_count = 0, cyc_n = 0;

  // 125 MHz clock
  always #4 sys_clk = ~sys_clk;

  // short counts keep the abort and recovery timers quick to reach
  phy_rx_tuning_regs #(.LIMIT_CYC(50), .MS_CYC(10), .LARGE_PKG(1'b1)) dut (
    .sys_clk(sys_clk), .rst(rst), .ce(ce),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
    .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .rx_frame_active(rx_frame_active), .descrambler_locked(descrambler_locked),
    .link_raw_ok(link_raw_ok), .symbol_valid(symbol_valid),
    .symbol_is_idle(symbol_is_idle), .nibble_valid(nibble_valid), .frame_end(frame_end),
    .rx_lane_a_skew(rx_lane_a_skew), .rx_lane_b_skew(rx_lane_b_skew),
    .strap_pins(strap_pins), .rx_abort(rx_abort),
    .descrambler_recovering(descrambler_recovering), .link_good(link_good),
    .enhanced_ternary_detect_on(enhanced_ternary_detect_on),
    .enhanced_gap_detect_on(enhanced_gap_detect_on),
    .rx_block_decoder_skip(rx_block_decoder_skip), .scrambler_off(scrambler_off),
    .early_receive_valid(early_receive_valid), .idle_mode(idle_mode),
    .odd_nibble_seen(odd_nibble_seen)
  );

  // second bank as the smaller package; shares every input, only read data watched
  phy_rx_tuning_regs #(.LIMIT_CYC(50), .MS_CYC(10), .LARGE_PKG(1'b0)) dut_small (
    .sys_clk(sys_clk), .rst(rst), .ce(ce),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(),
    .s_bresp(), .s_bvalid(), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(),
    .s_rdata(rdata_small), .s_rresp(), .s_rvalid(), .s_rready(s_rready),
    .rx_frame_active(rx_frame_active), .descrambler_locked(descrambler_locked),
    .link_raw_ok(link_raw_ok), .symbol_valid(symbol_valid),
    .symbol_is_idle(symbol_is_idle), .nibble_valid(nibble_valid), .frame_end(frame_end),
    .rx_lane_a_skew(rx_lane_a_skew), .rx_lane_b_skew(rx_lane_b_skew),
    .strap_pins(strap_pins), .rx_abort(), .descrambler_recovering(), .link_good(),
    .enhanced_ternary_detect_on(), .enhanced_gap_detect_on(), .rx_block_decoder_skip(),
    .scrambler_off(), .early_receive_valid(), .idle_mode(), .odd_nibble_seen()
  );

  // ---------------------------------------------------------------
  // report and compare
  // ---------------------------------------------------------------
  task automatic results();
    if (mismatches == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // watchdog: whole run needs well under 2000 cycles
  always @(posedge sys_clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      mismatches++;
      results();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // ---------------------------------------------------------------
  // bus tasks: aw and w offered together, each dropped when taken
  // ---------------------------------------------------------------
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                    input resp_t er);
    logic aw_d, w_d;
    aw_d = 1'b0;
    w_d = 1'b0;
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= s;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    while (!(aw_d && w_d)) begin
      @(posedge sys_clk);
      if (!aw_d && s_awready === 1'b1) begin
        aw_d = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w_d && s_wready === 1'b1) begin
        w_d = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    s_bready <= 1'b1;
    do @(posedge sys_clk); while (s_bvalid !== 1'b1);
    chk({30'h0, s_bresp}, {30'h0, er});
    s_bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] ed, input resp_t er);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    do @(posedge sys_clk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    s_rready <= 1'b1;
    do @(posedge sys_clk); while (s_rvalid !== 1'b1);
    chk(s_rdata, ed);
    chk({30'h0, s_rresp}, {30'h0, er});
    s_rready <= 1'b0;
  endtask

  // one symbol strobe followed by a quiet cycle
  task automatic sym(input logic idle);
    symbol_valid <= 1'b1;
    symbol_is_idle <= idle;
    cyc(1);
    symbol_valid <= 1'b0;
    cyc(1);
  endtask

  task automatic odd_run(input int n, input logic exp);
    repeat (n) begin
      nibble_valid <= 1'b1;
      cyc(1);
      nibble_valid <= 1'b0;
      cyc(1);
    end
    frame_end <= 1'b1;
    cyc(1);
    frame_end <= 1'b0;
    seen = 1'b0;
    repeat (4) begin
      cyc(1);
      seen = seen | odd_nibble_seen;
    end
    chk({31'h0, seen}, {31'h0, exp});
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    cyc(20);
    rst <= 1'b0;
    cyc(4);
    strap_pins <= 16'h0000; // pins move after capture; view must not follow
    // reset values
    rd(32'h0000_010C, 32'h0000_07A0, 2'b00);
    rd(32'h0000_014C, 32'h0000_2055, 2'b00);
    rd(32'h0000_0154, 32'h0000_0000, 2'b00);
    chk({31'h0, enhanced_ternary_detect_on}, 32'h0000_0001);
    chk({31'h0, link_good}, 32'h0000_0000);
    // straps frozen and read-only; bit 11 reserved
    rd(32'h0000_01B8, 32'h0000_F7FF, 2'b00);
    chk(rdata_small, 32'h0000_D7AF);
    wr(32'h0000_01B8, 32'h0000_0000, 4'hF, 2'b00);
    rd(32'h0000_01B8, 32'h0000_F7FF, 2'b00);
    // control bits all set, reserved 15:12 stay 0
    wr(32'h0000_010C, 32'hFFFF_FFFF, 4'hF, 2'b00);
    rd(32'h0000_010C, 32'h0000_0FFF, 2'b00);
    chk({27'h0, enhanced_ternary_detect_on, enhanced_gap_detect_on, rx_block_decoder_skip,
         scrambler_off, early_receive_valid}, 32'h0000_001F);
    chk({31'h0, link_good}, 32'h0000_0001);
    wr(32'h0000_010C, 32'h0000_0000, 4'hF, 2'b00);
    cyc(2);
    chk({26'h0, link_good, enhanced_ternary_detect_on, enhanced_gap_detect_on,
         rx_block_decoder_skip, scrambler_off, early_receive_valid}, 32'h0000_0000);
    // normal link evaluation, first frozen by the clock enable
    ce <= 1'b0;
    link_raw_ok <= 1'b1;
    cyc(3);
    chk({31'h0, link_good}, 32'h0000_0000);
    ce <= 1'b1;
    cyc(2);
    chk({31'h0, link_good}, 32'h0000_0001);
    link_raw_ok <= 1'b0;
    // upper byte strobe only
    wr(32'h0000_010C, 32'h0000_FFFF, 4'h2, 2'b00);
    rd(32'h0000_010C, 32'h0000_0F00, 2'b00);
    // overlong frame aborted while limit enabled
    wr(32'h0000_010C, 32'h0000_0000, 4'hF, 2'b00);
    rx_frame_active <= 1'b1;
    cyc(45);
    chk({31'h0, rx_abort}, 32'h0000_0000);
    cyc(12);
    chk({31'h0, rx_abort}, 32'h0000_0001);
    rx_frame_active <= 1'b0;
    cyc(4);
    chk({31'h0, rx_abort}, 32'h0000_0000);
    wr(32'h0000_010C, 32'h0000_0800, 4'hF, 2'b00);
    rx_frame_active <= 1'b1;
    cyc(70);
    chk({31'h0, rx_abort}, 32'h0000_0000);
    rx_frame_active <= 1'b0;
    // recovery of 2 ms after unlock
    wr(32'h0000_010C, 32'h0000_0100, 4'hF, 2'b00);
    descrambler_locked <= 1'b0;
    cyc(4);
    chk({31'h0, descrambler_recovering}, 32'h0000_0001);
    cyc(30);
    chk({31'h0, descrambler_recovering}, 32'h0000_0000);
    descrambler_locked <= 1'b1;
    // odd nibble flag only when enabled and count odd
    wr(32'h0000_010C, 32'h0000_0002, 4'hF, 2'b00);
    odd_run(3, 1'b1);
    odd_run(2, 1'b0);
    wr(32'h0000_010C, 32'h0000_0000, 4'hF, 2'b00);
    odd_run(3, 1'b0);
    // idle threshold: boundary value, then 4 used by the run test
    wr(32'h0000_014C, 32'hFFFF_FFFF, 4'hF, 2'b00);
    rd(32'h0000_014C, 32'h0000_205F, 2'b00);
    wr(32'h0000_014C, 32'h0000_0004, 4'hF, 2'b00);
    repeat (3) sym(1'b1);
    cyc(2);
    chk({31'h0, idle_mode}, 32'h0000_0000);
    sym(1'b1);
    cyc(2);
    chk({31'h0, idle_mode}, 32'h0000_0001);
    sym(1'b0);
    cyc(2);
    chk({31'h0, idle_mode}, 32'h0000_0000);
    // skew view follows lanes and ignores writes
    rx_lane_a_skew <= 4'h3;
    rx_lane_b_skew <= 4'hA;
    cyc(3);
    wr(32'h0000_0154, 32'h0000_FFFF, 4'hF, 2'b00);
    rd(32'h0000_0154, 32'h0000_00A3, 2'b00);
    // unmapped places refuse and leave state alone
    rd(32'h0000_0100, 32'h0000_0000, 2'b10);
    rd(32'h0000_050C, 32'h0000_0000, 2'b10);
    wr(32'h0000_0100, 32'h0000_FFFF, 4'hF, 2'b10);
    rd(32'h0000_010C, 32'h0000_0000, 2'b00);
    results();
  end
endmodule // tb
`default_nettype wire
